// [core/awc_window.v]
// Window comparator on the primary converter, with its conversion sequencer and byte registers.
`include "awc_defs.vh"

module awc_window (
	input wire clock,
	input wire rstn,
	input wire ce,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire conv_trig_pin,
	input wire [9:0] sar_code,
	output reg [7:0] sfr_rdata,
	output reg window_match_flag,
	output reg conv_busy,
	output reg sar_sample
);

	localparam ST_IDLE = 2'b00;
	localparam ST_CONV = 2'b01;
	localparam ST_CMP = 2'b10;

	localparam integer SAR_DIV_INT = `AWC_SAR_DIV;
	localparam integer CONV_CLKS_INT = `AWC_CONV_SAR_CLKS;
	localparam [7:0] SAR_DIV = SAR_DIV_INT[7:0];
	localparam [4:0] CONV_CLKS = CONV_CLKS_INT[4:0];

	reg [7:0] upper_limit_low_byte_reg;
	reg [7:0] upper_limit_high_byte_reg;
	reg [7:0] lower_limit_low_byte_reg;
	reg [7:0] lower_limit_high_byte_reg;
	reg left_justify_select_reg;
	reg diff_mode_reg;
	reg trig_en_reg;
	reg done_reg;
	reg [7:0] res_lo_reg;
	reg [7:0] res_hi_reg;
	reg [1:0] state_reg;
	reg [7:0] div_cnt_reg;
	reg [4:0] sar_cnt_reg;
	reg trig_s1_reg;
	reg trig_s2_reg;
	reg trig_s3_reg;

	wire wr_ctrl;
	wire sw_start;
	wire trig_edge;
	wire start_req;
	wire sar_tick;
	wire [15:0] gt_word;
	wire [15:0] lt_word;
	reg [15:0] result_word;
	reg match;

	assign wr_ctrl = sfr_wr && (sfr_addr == `AWC_ADDR_CTRL);
	// Writing one to the busy bit starts a conversion, as does a rising edge on the trigger pin.
	assign sw_start = wr_ctrl && sfr_wdata[`AWC_BIT_BUSY];
	assign trig_edge = trig_en_reg && trig_s2_reg && !trig_s3_reg;
	assign start_req = sw_start || trig_edge;
	assign sar_tick = (div_cnt_reg == SAR_DIV - 8'h01);
	assign gt_word = {upper_limit_high_byte_reg, upper_limit_low_byte_reg};
	assign lt_word = {lower_limit_high_byte_reg, lower_limit_low_byte_reg};

	// Trigger pin comes from outside the clock domain; the second and third stages feed the edge detector.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else if (ce) begin
			trig_s1_reg <= conv_trig_pin;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	// Justify the raw code into the 16-bit data word used for storage and comparison.
	always @* begin
		if (left_justify_select_reg) begin
			result_word = {sar_code, 6'h00};
		end else if (diff_mode_reg) begin
			result_word = {{6{sar_code[9]}}, sar_code};
		end else begin
			result_word = {6'h00, sar_code};
		end
	end

	// Differential readings are two's complement, so they compare signed against the limits.
	always @* begin
		match = 1'b0;
		if (diff_mode_reg) begin
			if ($signed(lt_word) > $signed(gt_word)) begin
				match = ($signed(result_word) > $signed(gt_word)) &&
					($signed(result_word) < $signed(lt_word));
			end else begin
				match = ($signed(result_word) < $signed(lt_word)) ||
					($signed(result_word) > $signed(gt_word));
			end
		end else begin
			if (lt_word > gt_word) begin
				match = (result_word > gt_word) && (result_word < lt_word);
			end else begin
				match = (result_word < lt_word) || (result_word > gt_word);
			end
		end
	end

	// Conversion sequencer: a start is ignored while a conversion is running.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			div_cnt_reg <= 8'h00;
			sar_cnt_reg <= 5'h00;
			conv_busy <= 1'b0;
			sar_sample <= 1'b0;
		end else if (ce) begin
			sar_sample <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (start_req) begin
					state_reg <= ST_CONV;
					div_cnt_reg <= 8'h00;
					sar_cnt_reg <= 5'h00;
					conv_busy <= 1'b1;
				end
			end
			ST_CONV: begin
				if (sar_tick) begin
					div_cnt_reg <= 8'h00;
					if (sar_cnt_reg == CONV_CLKS - 5'h01) begin
						state_reg <= ST_CMP;
						sar_sample <= 1'b1;
					end else begin
						sar_cnt_reg <= sar_cnt_reg + 5'h01;
					end
				end else begin
					div_cnt_reg <= div_cnt_reg + 8'h01;
				end
			end
			ST_CMP: begin
				state_reg <= ST_IDLE;
				conv_busy <= 1'b0;
			end
			default: begin
				state_reg <= ST_IDLE;
				conv_busy <= 1'b0;
			end
			endcase
		end
	end

	// Register file and status flags. A hardware set wins over a software clear in one cycle.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			upper_limit_low_byte_reg <= `AWC_RST_GT_LO;
			upper_limit_high_byte_reg <= `AWC_RST_GT_HI;
			lower_limit_low_byte_reg <= `AWC_RST_LT_LO;
			lower_limit_high_byte_reg <= `AWC_RST_LT_HI;
			left_justify_select_reg <= 1'b0;
			diff_mode_reg <= 1'b0;
			trig_en_reg <= 1'b0;
			done_reg <= 1'b0;
			window_match_flag <= 1'b0;
			res_lo_reg <= `AWC_RST_RES;
			res_hi_reg <= `AWC_RST_RES;
		end else if (ce) begin
			if (sfr_wr) begin
				case (sfr_addr)
				`AWC_ADDR_GT_LO: upper_limit_low_byte_reg <= sfr_wdata;
				`AWC_ADDR_GT_HI: upper_limit_high_byte_reg <= sfr_wdata;
				`AWC_ADDR_LT_LO: lower_limit_low_byte_reg <= sfr_wdata;
				`AWC_ADDR_LT_HI: lower_limit_high_byte_reg <= sfr_wdata;
				`AWC_ADDR_CTRL: begin
					left_justify_select_reg <= sfr_wdata[`AWC_BIT_LJUST];
					diff_mode_reg <= sfr_wdata[`AWC_BIT_DIFF];
					trig_en_reg <= sfr_wdata[`AWC_BIT_TRIGEN];
					done_reg <= sfr_wdata[`AWC_BIT_DONE];
					window_match_flag <= sfr_wdata[`AWC_BIT_WFLAG];
				end
				default: begin
				end
				endcase
			end
			// Result and compare happen on the same edge, so software never starts a compare.
			if (sar_sample) begin
				res_lo_reg <= result_word[7:0];
				res_hi_reg <= result_word[15:8];
				done_reg <= 1'b1;
				if (match) begin
					window_match_flag <= 1'b1;
				end
			end
		end
	end

	// Read data is registered; unmapped addresses read as zero.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
		end else if (ce) begin
			if (sfr_rd) begin
				case (sfr_addr)
				`AWC_ADDR_GT_LO: sfr_rdata <= upper_limit_low_byte_reg;
				`AWC_ADDR_GT_HI: sfr_rdata <= upper_limit_high_byte_reg;
				`AWC_ADDR_LT_LO: sfr_rdata <= lower_limit_low_byte_reg;
				`AWC_ADDR_LT_HI: sfr_rdata <= lower_limit_high_byte_reg;
				`AWC_ADDR_RES_LO: sfr_rdata <= res_lo_reg;
				`AWC_ADDR_RES_HI: sfr_rdata <= res_hi_reg;
				`AWC_ADDR_CTRL: begin
					sfr_rdata <= {2'b00, trig_en_reg, conv_busy, done_reg, diff_mode_reg,
						window_match_flag, left_justify_select_reg};
				end
				default: sfr_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule // awc_window

// [core/awc_defs.vh]
// Constants for the converter window comparator: addresses, fields, resets and timing.
`ifndef AWC_DEFS_VH
`define AWC_DEFS_VH

// Special-function register addresses.
`define AWC_ADDR_CTRL 8'hE8
`define AWC_ADDR_RES_LO 8'hBE
`define AWC_ADDR_RES_HI 8'hBF
`define AWC_ADDR_GT_LO 8'hC4
`define AWC_ADDR_GT_HI 8'hC5
`define AWC_ADDR_LT_LO 8'hC6
`define AWC_ADDR_LT_HI 8'hC7

// Control register bit positions.
`define AWC_BIT_LJUST 0
`define AWC_BIT_WFLAG 1
`define AWC_BIT_DIFF 2
`define AWC_BIT_DONE 3
`define AWC_BIT_BUSY 4
`define AWC_BIT_TRIGEN 5

// Reset values.
`define AWC_RST_CTRL 8'h00
`define AWC_RST_GT_LO 8'hFF
`define AWC_RST_GT_HI 8'hFF
`define AWC_RST_LT_LO 8'h00
`define AWC_RST_LT_HI 8'h00
`define AWC_RST_RES 8'h00

// Timing: system clock period and least converter clock period, in ns.
`define AWC_SYS_CLK_NS 10
`define AWC_SAR_CLK_MIN_NS 400
`define AWC_SAR_DIV ((`AWC_SAR_CLK_MIN_NS + `AWC_SYS_CLK_NS - 1) / `AWC_SYS_CLK_NS)
`define AWC_CONV_SAR_CLKS 16

`endif

// [core/awc_pad.v]
// Spare design file: all comparator logic lives in the window module.

// [tb/awc_window_assertions.sv]
// Checker for the window comparator's port behaviour.
module awc_chk (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic conv_trig_pin,
	input wire logic [9:0] sar_code,
	input wire logic [7:0] sfr_rdata,
	input wire logic window_match_flag,
	input wire logic conv_busy,
	input wire logic sar_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire ctl_wr = ce && sfr_wr && sfr_addr == 8'hE8;
	// Counts enabled cycles spent busy, so the minimum conversion length can be checked.
	logic [9:0] busy_cnt;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy_cnt <= 10'h000;
		end else if (ce) begin
			busy_cnt <= conv_busy ? busy_cnt + 10'h001 : 10'h000;
		end
	end
	property p_start; ctl_wr && sfr_wdata[4] && !conv_busy |=> conv_busy; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_min; sar_sample |-> busy_cnt >= 10'h280; endproperty
	a_min: assert property (p_min) else $error("early result");
	property p_in; sar_sample |-> conv_busy; endproperty
	a_in: assert property (p_in) else $error("result while idle");
	property p_end; sar_sample && ce |=> !conv_busy && !sar_sample; endproperty
	a_end: assert property (p_end) else $error("busy stuck");
	property p_src; $rose(window_match_flag) |-> $past(sar_sample) || $past(ctl_wr); endproperty
	a_src: assert property (p_src) else $error("flag without cause");
	property p_hold; window_match_flag && !ctl_wr |=> window_match_flag; endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_unmap; ce && sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_rdh; !(ce && sfr_rd) |=> $stable(sfr_rdata); endproperty
	a_rdh: assert property (p_rdh) else $error("read data moved");
endmodule // awc_chk

bind awc_window awc_chk awc_chk_i (.clock(clock), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .conv_trig_pin(conv_trig_pin),
	.sar_code(sar_code), .sfr_rdata(sfr_rdata), .window_match_flag(window_match_flag),
	.conv_busy(conv_busy), .sar_sample(sar_sample));

// [tb/awc_sar_model.sv]
// Behavioural source of the raw converter code.
module awc_sar_model (
	input wire logic clock,
	input wire logic [9:0] code_set,
	output logic [9:0] sar_code
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered so the code never changes in the capture edge's time step.
	always @(posedge clock) begin
		sar_code <= code_set;
	end
endmodule // awc_sar_model

// [tb/test_adc_window_comparator.sv]
// Self-checking bench for the converter window comparator.
module test_adc_window_comparator;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [9:0] code_set = 10'h000;
	logic ce = 1'b1;
	logic conv_trig_pin = 1'b0;
	wire [9:0] sar_code;
	wire [7:0] sfr_rdata;
	wire window_match_flag;
	wire conv_busy;
	wire sar_sample;
	int bad_count = 0;
	int n_checks = 0;
	always #5 clock = ~clock;
	awc_sar_model awc_sar_model_i (.clock(clock), .code_set(code_set), .sar_code(sar_code));
	awc_window awc_window_i (.clock(clock), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .conv_trig_pin(conv_trig_pin),
		.sar_code(sar_code), .sfr_rdata(sfr_rdata), .window_match_flag(window_match_flag),
		.conv_busy(conv_busy), .sar_sample(sar_sample));
	task automatic finish_test();
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
	endtask
	// Writing the control byte with the flag bit low also clears the previous match.
	task automatic win(input logic [15:0] gt, input logic [15:0] lt, input logic [7:0] mode,
		input logic [9:0] code, input logic exp);
		int n;
		logic [15:0] w;
		wr(8'hC5, gt[15:8]);
		wr(8'hC4, gt[7:0]);
		wr(8'hC7, lt[15:8]);
		wr(8'hC6, lt[7:0]);
		code_set = code;
		wr(8'hE8, mode | 8'h10);
		n = 0;
		while (sar_sample !== 1'b1 && n < 700) begin
			@(negedge clock);
			n++;
		end
		chk({7'h00, n >= 640 && n <= 641}, 8'h01);
		@(negedge clock);
		chk({7'h00, window_match_flag}, {7'h00, exp});
		rd(8'hE8, {mode[7:2], exp, mode[0]} | 8'h08);
		w = mode[0] ? {code, 6'h00} : (mode[2] ? {{6{code[9]}}, code} : {6'h00, code});
		rd(8'hBF, w[15:8]);
		rd(8'hBE, w[7:0]);
	endtask
	// A pin edge must pass the synchroniser, and a low clock enable must freeze everything.
	task automatic t_trig();
		int n;
		wr(8'hC5, 8'h00);
		wr(8'hC4, 8'h10);
		wr(8'hC7, 8'h00);
		wr(8'hC6, 8'h20);
		code_set = 10'h018;
		wr(8'hE8, 8'h20);
		@(negedge clock);
		conv_trig_pin = 1'b1;
		repeat (2) @(negedge clock);
		chk({7'h00, conv_busy}, 8'h00);
		@(negedge clock);
		chk({7'h00, conv_busy}, 8'h01);
		conv_trig_pin = 1'b0;
		ce = 1'b0;
		wr(8'hC4, 8'hEE);
		repeat (48) @(negedge clock);
		ce = 1'b1;
		n = 0;
		while (sar_sample !== 1'b1 && n < 760) begin
			@(negedge clock);
			n++;
		end
		chk({7'h00, n >= 640 && n <= 641}, 8'h01);
		@(negedge clock);
		chk({7'h00, window_match_flag}, 8'h01);
		rd(8'hE8, 8'h2A);
		rd(8'hC4, 8'h10);
		rd(8'hBF, 8'h00);
		rd(8'hBE, 8'h18);
	endtask
	task automatic t_regs();
		rd(8'hC4, 8'hFF);
		rd(8'hC7, 8'h00);
		rd(8'hC5, 8'hFF);
		wr(8'hBE, 8'h55);
		rd(8'hBE, 8'h00);
		wr(8'hC7, 8'h5A);
		rd(8'hC7, 8'h5A);
		wr(8'hC4, 8'h12);
		rd(8'hC4, 8'h12);
		wr(8'hC6, 8'hA5);
		rd(8'hC6, 8'hA5);
		rd(8'h00, 8'h00);
	endtask
	task automatic t_outside();
		win(16'h0200, 16'h0100, 8'h00, 10'h050, 1'b1);
		win(16'h0200, 16'h0100, 8'h00, 10'h150, 1'b0);
		win(16'h0200, 16'h0100, 8'h00, 10'h300, 1'b1);
	endtask
	task automatic t_inside();
		win(16'h0100, 16'h0200, 8'h00, 10'h150, 1'b1);
		win(16'h0100, 16'h0200, 8'h00, 10'h100, 1'b0);
		win(16'h0100, 16'h0200, 8'h00, 10'h300, 1'b0);
	endtask
	task automatic t_format();
		win(16'h4000, 16'h8000, 8'h01, 10'h200, 1'b0);
		win(16'h4000, 16'h8000, 8'h01, 10'h180, 1'b1);
		win(16'hFFF0, 16'h0010, 8'h04, 10'h3FF, 1'b1);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		t_regs();
		t_outside();
		t_inside();
		t_format();
		t_trig();
		finish_test();
	end
	// Ten conversions of under 750 cycles each fit well inside this span.
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
endmodule // test_adc_window_comparator
